/* design/pbv_pkg.sv */
// constants and types of the push-button volume control
package pbv_pkg;
    // ---------------------------------------------------------------
    // register offsets and reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] SETUP_ADDR      = 8'h3f;
    localparam logic [7:0] ASSIGN_ADDR     = 8'h40;
    localparam logic [7:0] FILTER_ADDR     = 8'h41;
    localparam logic [7:0] LEVEL_ADDR      = 8'h42;
    localparam logic [7:0] SETUP_RESET     = 8'h00;
    localparam logic [7:0] ASSIGN_RESET    = 8'h87;
    localparam logic [7:0] FILTER_RESET    = 8'h05;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int STEP_LSB   = 6;
    localparam int RATE_LSB   = 3;
    localparam int TARGET_LSB = 0;
    localparam int START_LSB  = 3;
    localparam int HOLD_LSB   = 0;
    localparam int DEB_LSB    = 0;

    localparam logic [2:0] TARGET_NONE     = 3'h7;
    localparam logic [2:0] TARGET_RESERVED = 3'h6;
    localparam logic [2:0] DEB_BYPASS      = 3'h7;
    localparam logic [4:0] FUNC_VOL_UP     = 5'h10;
    localparam logic [4:0] FUNC_VOL_DOWN   = 5'h11;

    // ---------------------------------------------------------------
    // level units: one unit is 0.375 dB of attenuation
    // ---------------------------------------------------------------
    localparam logic [7:0] LEVEL_MIN_GAIN  = 8'hff;
    localparam logic [7:0] UNITS_PER_START = 8'h04;
    localparam logic [7:0] STEP_0375_DB    = 8'h01;
    localparam logic [7:0] STEP_1500_DB    = 8'h04;
    localparam logic [7:0] STEP_3000_DB    = 8'h08;
    localparam logic [7:0] STEP_4500_DB    = 8'h0c;
    localparam int         UNIT_MILLI_DB   = 375;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_MHZ   = 200;
    localparam int TICK_US   = 1;
    localparam int TICK_CYC  = TICK_US * CLK_MHZ;
    localparam int CNT_W     = 21;

    localparam int DEB0_US = 300;
    localparam int DEB1_US = 600;
    localparam int DEB2_US = 900;
    localparam int DEB3_MS = 5;
    localparam int DEB4_MS = 10;
    localparam int DEB5_MS = 20;
    localparam int DEB6_MS = 40;

    localparam int HOLD0_MS = 150;
    localparam int HOLD1_MS = 300;
    localparam int HOLD2_MS = 450;
    localparam int HOLD3_MS = 600;
    localparam int HOLD4_MS = 900;
    localparam int HOLD5_MS = 1200;

    localparam int RATE0_DBS = 60;
    localparam int RATE1_DBS = 48;
    localparam int RATE2_DBS = 36;
    localparam int RATE3_DBS = 30;
    localparam int RATE4_DBS = 24;
    localparam int RATE5_DBS = 18;
    localparam int RATE6_DBS = 12;
    localparam int RATE7_DBS = 6;

    localparam int NUM_CONV = 6;

    typedef enum logic [1:0] {
        PBV_IDLE = 2'b00,
        PBV_HOLD = 2'b01,
        PBV_RAMP = 2'b11
    } pbv_state_t;
endpackage

/* design/pbv_pin_filter.sv */
// synchroniser and debounce filter for one multipurpose pin
`timescale 1ns/1ps
module pbv_pin_filter (
    input  wire logic                      clk_sys_in,
    input  wire logic                      sys_rst_in,
    input  wire logic                      pin_in,
    input  wire logic                      tick_in,
    input  wire logic                      bypass_in,
    input  wire logic [pbv_pkg::CNT_W-1:0] limit_us_in,
    output logic                           level_out
);
    logic                      meta_q, sync_q, stable_q, stable_d;
    logic [pbv_pkg::CNT_W-1:0] cnt_q, cnt_d;

    always_comb begin
        stable_d = stable_q;
        cnt_d    = cnt_q;
        if (bypass_in) begin
            stable_d = sync_q;
            cnt_d    = '0;
        end else if (sync_q == stable_q) begin
            cnt_d = '0;
        end else if (tick_in) begin
            // level must stay changed for the whole filter time
            if (cnt_q + 1'b1 >= limit_us_in) begin
                stable_d = sync_q;
                cnt_d    = '0;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            meta_q   <= 1'b0;
            sync_q   <= 1'b0;
            stable_q <= 1'b0;
            cnt_q    <= '0;
        end else begin
            meta_q   <= pin_in;
            sync_q   <= meta_q;
            stable_q <= stable_d;
            cnt_q    <= cnt_d;
        end
    end

    assign level_out = stable_q;
endmodule

/* design/pbv_ctrl.sv */
// push-button volume control: registers, button state machine and gain select
`timescale 1ns/1ps
module pbv_ctrl #(
    parameter int NUM_PINS    = 5,
    parameter int TICK_CYCLES = pbv_pkg::TICK_CYC
) (
    input  wire logic                            clk_sys_in,
    input  wire logic                            sys_rst_in,
    input  wire logic [7:0]                      reg_addr_in,
    input  wire logic [7:0]                      reg_wdata_in,
    input  wire logic                            reg_wr_in,
    output logic [7:0]                           reg_rdata_out,
    input  wire logic [NUM_PINS-1:0]             multipurpose_pins_in,
    input  wire logic [NUM_PINS*5-1:0]           pin_function_in,
    input  wire logic [4*8-1:0]                  adc_channel_gain_reg_in,
    input  wire logic [2*8-1:0]                  dac_channel_gain_reg_in,
    output logic [pbv_pkg::NUM_CONV*8-1:0]       conv_gain_out,
    output logic [7:0]                           button_level_out
);
    localparam int NC = pbv_pkg::NUM_CONV;

    // ---------------------------------------------------------------
    // decode functions
    // ---------------------------------------------------------------
    function automatic logic [pbv_pkg::CNT_W-1:0] deb_limit(input logic [2:0] code);
        int us;
        case (code)
            3'h0:    us = pbv_pkg::DEB0_US;
            3'h1:    us = pbv_pkg::DEB1_US;
            3'h2:    us = pbv_pkg::DEB2_US;
            3'h3:    us = pbv_pkg::DEB3_MS * 1000;
            3'h4:    us = pbv_pkg::DEB4_MS * 1000;
            3'h5:    us = pbv_pkg::DEB5_MS * 1000;
            default: us = pbv_pkg::DEB6_MS * 1000;
        endcase
        return pbv_pkg::CNT_W'(us / pbv_pkg::TICK_US);
    endfunction

    function automatic logic [pbv_pkg::CNT_W-1:0] hold_limit(input logic [2:0] code);
        int ms;
        case (code)
            3'h0:    ms = pbv_pkg::HOLD0_MS;
            3'h1:    ms = pbv_pkg::HOLD1_MS;
            3'h2:    ms = pbv_pkg::HOLD2_MS;
            3'h3:    ms = pbv_pkg::HOLD3_MS;
            3'h4:    ms = pbv_pkg::HOLD4_MS;
            default: ms = pbv_pkg::HOLD5_MS;
        endcase
        return pbv_pkg::CNT_W'(ms * 1000 / pbv_pkg::TICK_US);
    endfunction

    // microseconds per 0.375 dB unit, rounded down
    function automatic logic [pbv_pkg::CNT_W-1:0] ramp_limit(input logic [2:0] code);
        int r;
        case (code)
            3'h0:    r = pbv_pkg::RATE0_DBS;
            3'h1:    r = pbv_pkg::RATE1_DBS;
            3'h2:    r = pbv_pkg::RATE2_DBS;
            3'h3:    r = pbv_pkg::RATE3_DBS;
            3'h4:    r = pbv_pkg::RATE4_DBS;
            3'h5:    r = pbv_pkg::RATE5_DBS;
            3'h6:    r = pbv_pkg::RATE6_DBS;
            default: r = pbv_pkg::RATE7_DBS;
        endcase
        return pbv_pkg::CNT_W'(pbv_pkg::UNIT_MILLI_DB * 1000 / r / pbv_pkg::TICK_US);
    endfunction

    function automatic logic [NC-1:0] target_mask(input logic [2:0] t);
        case (t)
            3'h0:    target_mask = 6'b000011;
            3'h1:    target_mask = 6'b001100;
            3'h2:    target_mask = 6'b001111;
            3'h3:    target_mask = 6'b110000;
            3'h4:    target_mask = 6'b010000;
            3'h5:    target_mask = 6'b100000;
            default: target_mask = 6'b000000;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0] setup_q, setup_d, assign_q, assign_d, filter_q, filter_d, rdata_q, rdata_d;
    logic       setup_wr_q, setup_wr_d;
    logic [7:0] level_q, level_d;

    always_comb begin
        setup_d    = setup_q;
        assign_d   = assign_q;
        filter_d   = filter_q;
        setup_wr_d = setup_wr_q;
        case (reg_addr_in)
            pbv_pkg::SETUP_ADDR:  rdata_d = setup_q;
            pbv_pkg::ASSIGN_ADDR: rdata_d = assign_q;
            pbv_pkg::FILTER_ADDR: rdata_d = filter_q;
            pbv_pkg::LEVEL_ADDR:  rdata_d = level_q;
            default:              rdata_d = 8'h00;
        endcase
        if (reg_wr_in) begin
            case (reg_addr_in)
                pbv_pkg::SETUP_ADDR: begin
                    setup_d    = reg_wdata_in;
                    setup_wr_d = 1'b1;
                end
                pbv_pkg::ASSIGN_ADDR: assign_d = reg_wdata_in;
                pbv_pkg::FILTER_ADDR: filter_d = reg_wdata_in;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            setup_q    <= pbv_pkg::SETUP_RESET;
            assign_q   <= pbv_pkg::ASSIGN_RESET;
            filter_q   <= pbv_pkg::FILTER_RESET;
            setup_wr_q <= 1'b0;
            rdata_q    <= 8'h00;
        end else begin
            setup_q    <= setup_d;
            assign_q   <= assign_d;
            filter_q   <= filter_d;
            setup_wr_q <= setup_wr_d;
            rdata_q    <= rdata_d;
        end
    end

    assign reg_rdata_out = rdata_q;

    wire [1:0] step_f   = assign_q[pbv_pkg::STEP_LSB +: 2];
    wire [2:0] rate_f   = assign_q[pbv_pkg::RATE_LSB +: 3];
    wire [2:0] target_f = assign_q[pbv_pkg::TARGET_LSB +: 3];
    wire [4:0] start_f  = setup_q[pbv_pkg::START_LSB +: 5];
    wire [2:0] hold_f   = setup_q[pbv_pkg::HOLD_LSB +: 3];
    wire [2:0] deb_f    = filter_q[pbv_pkg::DEB_LSB +: 3];

    // ---------------------------------------------------------------
    // microsecond tick
    // ---------------------------------------------------------------
    logic [15:0] tick_cnt_q, tick_cnt_d;
    logic        tick;

    always_comb begin
        tick       = (tick_cnt_q == 16'(TICK_CYCLES - 1));
        tick_cnt_d = tick ? 16'h0000 : tick_cnt_q + 16'h0001;
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) tick_cnt_q <= 16'h0000;
        else            tick_cnt_q <= tick_cnt_d;
    end

    // ---------------------------------------------------------------
    // pin filters and button decode
    // ---------------------------------------------------------------
    logic [NUM_PINS-1:0] pin_level, up_hit, down_hit;

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            pbv_pin_filter u_filter (
                .clk_sys_in  (clk_sys_in),
                .sys_rst_in  (sys_rst_in),
                .pin_in      (multipurpose_pins_in[g]),
                .tick_in     (tick),
                .bypass_in   (deb_f == pbv_pkg::DEB_BYPASS),
                .limit_us_in (deb_limit(deb_f)),
                .level_out   (pin_level[g])
            );
            assign up_hit[g]   = pin_level[g] && (pin_function_in[g*5 +: 5] == pbv_pkg::FUNC_VOL_UP);
            assign down_hit[g] = pin_level[g] && (pin_function_in[g*5 +: 5] == pbv_pkg::FUNC_VOL_DOWN);
        end
    endgenerate

    wire up_btn   = |up_hit;
    wire down_btn = |down_hit;
    // pressing both at once is treated as no press
    wire one_btn  = up_btn ^ down_btn;

    // ---------------------------------------------------------------
    // button state machine and level
    // ---------------------------------------------------------------
    pbv_pkg::pbv_state_t      state_q, state_d;
    logic [pbv_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic                     dir_up_q, dir_up_d;
    logic                     active_q;
    logic [7:0]               step_units, delta;
    logic [8:0]               sum;
    logic                     apply;

    wire active = (target_f != pbv_pkg::TARGET_NONE);

    always_comb begin
        case (step_f)
            2'h0:    step_units = pbv_pkg::STEP_0375_DB;
            2'h1:    step_units = pbv_pkg::STEP_1500_DB;
            2'h2:    step_units = pbv_pkg::STEP_3000_DB;
            default: step_units = pbv_pkg::STEP_4500_DB;
        endcase
        state_d  = state_q;
        cnt_d    = cnt_q;
        dir_up_d = dir_up_q;
        apply    = 1'b0;
        delta    = step_units;
        case (state_q)
            pbv_pkg::PBV_IDLE: begin
                cnt_d = '0;
                if (active && one_btn) begin
                    apply    = 1'b1;
                    dir_up_d = up_btn;
                    state_d  = pbv_pkg::PBV_HOLD;
                end
            end
            pbv_pkg::PBV_HOLD: begin
                if (!active || !one_btn || (up_btn != dir_up_q)) begin
                    state_d = pbv_pkg::PBV_IDLE;
                end else if (tick) begin
                    if (cnt_q + 1'b1 >= hold_limit(hold_f)) begin
                        cnt_d   = '0;
                        state_d = pbv_pkg::PBV_RAMP;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
            end
            pbv_pkg::PBV_RAMP: begin
                delta = 8'h01;
                if (!active || !one_btn || (up_btn != dir_up_q)) begin
                    state_d = pbv_pkg::PBV_IDLE;
                end else if (tick) begin
                    // one 0.375 dB unit per rate interval
                    if (cnt_q + 1'b1 >= ramp_limit(rate_f)) begin
                        cnt_d = '0;
                        apply = 1'b1;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
            end
            default: state_d = pbv_pkg::PBV_IDLE;
        endcase

        level_d = level_q;
        if (active && !active_q) begin
            // start level, 95.625 dB when setup never written
            level_d = setup_wr_q ? 8'({3'h0, start_f} * pbv_pkg::UNITS_PER_START) : pbv_pkg::LEVEL_MIN_GAIN;
        end else if (apply) begin
            // level is attenuation: up lowers it, both ends saturate
            if (dir_up_d) begin
                sum     = {1'b0, level_q} - {1'b0, delta};
                level_d = sum[8] ? 8'h00 : sum[7:0];
            end else begin
                sum     = {1'b0, level_q} + {1'b0, delta};
                level_d = sum[8] ? pbv_pkg::LEVEL_MIN_GAIN : sum[7:0];
            end
        end
        sum = 9'h000;
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q  <= pbv_pkg::PBV_IDLE;
            cnt_q    <= '0;
            dir_up_q <= 1'b0;
            active_q <= 1'b0;
            level_q  <= pbv_pkg::LEVEL_MIN_GAIN;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            dir_up_q <= dir_up_d;
            active_q <= active;
            level_q  <= level_d;
        end
    end

    assign button_level_out = level_q;

    // ---------------------------------------------------------------
    // per-converter gain select
    // ---------------------------------------------------------------
    logic [NC*8-1:0] gain_q, gain_d;
    logic [NC-1:0]   mask;

    always_comb begin
        mask = active ? target_mask(target_f) : '0;
        for (int i = 0; i < NC; i++) begin
            if (mask[i])      gain_d[i*8 +: 8] = level_q;
            else if (i < 4)   gain_d[i*8 +: 8] = adc_channel_gain_reg_in[(i%4)*8 +: 8];
            else              gain_d[i*8 +: 8] = dac_channel_gain_reg_in[(i%2)*8 +: 8];
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) gain_q <= '0;
        else            gain_q <= gain_d;
    end

    assign conv_gain_out = gain_q;
endmodule

/* sim/pbv_buttons.sv */
// bouncing mechanical push buttons on the multipurpose pins
`timescale 1ns/1ps
module pbv_buttons #(
    parameter int NUM_PINS = 5,
    parameter int BOUNCES  = 4
) (
    input  wire logic                clk_sys_in,
    input  wire logic                chatter_in,
    input  wire logic [NUM_PINS-1:0] press_in,
    output logic      [NUM_PINS-1:0] multipurpose_pins_out
);
    // released contacts sit on the pull-down; pressed contacts pull high
    logic [NUM_PINS-1:0] settled_q           = '0;
    int                  chatter_q[NUM_PINS] = '{default: 0};

    // with chatter_in set, contacts toggle for a while after each change, which only a filter can hide
    always @(posedge clk_sys_in) begin
        for (int g = 0; g < NUM_PINS; g++) begin
            if (press_in[g] != settled_q[g]) begin
                settled_q[g] <= press_in[g];
                chatter_q[g] <= chatter_in ? 2 * BOUNCES : 0;
            end else if (chatter_q[g] > 0) begin
                chatter_q[g] <= chatter_q[g] - 1;
            end
        end
    end

    always_comb begin
        for (int g = 0; g < NUM_PINS; g++) begin
            multipurpose_pins_out[g] = (chatter_q[g] > 0) ? chatter_q[g][0] : settled_q[g];
        end
    end
endmodule

/* sim/pbv_ctrl_checker.sv */
// concurrent checks on the ports of the push-button volume control
`timescale 1ns/1ps
module pbv_ctrl_checker #(
    parameter int NUM_PINS    = 5,
    parameter int TICK_CYCLES = 2
) (
    input wire logic                               clk_sys_in,
    input wire logic                               sys_rst_in,
    input wire logic [7:0]                         reg_addr_in,
    input wire logic [7:0]                         reg_wdata_in,
    input wire logic                               reg_wr_in,
    input wire logic [7:0]                         reg_rdata_out,
    input wire logic [NUM_PINS-1:0]                multipurpose_pins_in,
    input wire logic [4*8-1:0]                     adc_channel_gain_reg_in,
    input wire logic [2*8-1:0]                     dac_channel_gain_reg_in,
    input wire logic [pbv_pkg::NUM_CONV*8-1:0]     conv_gain_out,
    input wire logic [7:0]                         button_level_out
);
    // shadow registers rebuilt from the write port
    logic [7:0] setup_q, setup_d, assign_q, assign_d, filter_q, filter_d, pin_hist_q, pin_hist_d;
    logic       seen_q, seen_d;

    always_comb begin
        setup_d    = setup_q;
        assign_d   = assign_q;
        filter_d   = filter_q;
        seen_d     = seen_q | (reg_wr_in && reg_addr_in == pbv_pkg::SETUP_ADDR);
        pin_hist_d = {pin_hist_q[6:0], |multipurpose_pins_in};
        if (reg_wr_in && reg_addr_in == pbv_pkg::SETUP_ADDR) setup_d = reg_wdata_in;
        if (reg_wr_in && reg_addr_in == pbv_pkg::ASSIGN_ADDR) assign_d = reg_wdata_in;
        if (reg_wr_in && reg_addr_in == pbv_pkg::FILTER_ADDR) filter_d = reg_wdata_in;
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            setup_q    <= pbv_pkg::SETUP_RESET;
            assign_q   <= pbv_pkg::ASSIGN_RESET;
            filter_q   <= pbv_pkg::FILTER_RESET;
            seen_q     <= 1'b0;
            pin_hist_q <= 8'h00;
        end else begin
            setup_q    <= setup_d;
            assign_q   <= assign_d;
            filter_q   <= filter_d;
            seen_q     <= seen_d;
            pin_hist_q <= pin_hist_d;
        end
    end

    function automatic logic [7:0] rd_exp(input logic [7:0] a, s, g, f, l);
        case (a)
            pbv_pkg::SETUP_ADDR:  return s;
            pbv_pkg::ASSIGN_ADDR: return g;
            pbv_pkg::FILTER_ADDR: return f;
            pbv_pkg::LEVEL_ADDR:  return l;
            default:              return 8'h00;
        endcase
    endfunction

    function automatic logic [47:0] gain_exp(input logic [2:0] t, input logic [7:0] l, input logic [47:0] sw);
        logic [5:0] sel;
        sel = (t == 3'h0) ? 6'h03 : (t == 3'h1) ? 6'h0c : (t == 3'h2) ? 6'h0f :
              (t == 3'h3) ? 6'h30 : (t == 3'h4) ? 6'h10 : (t == 3'h5) ? 6'h20 : 6'h00;
        gain_exp = sw;
        for (int i = 0; i < 6; i++) if (sel[i]) gain_exp[i*8+:8] = l;
    endfunction

    // a press moves at most one gain step, a ramp one unit
    function automatic logic [8:0] step_units(input logic [1:0] c);
        return (c == 2'h0) ? 9'h001 : {5'h00, c, 2'b00};
    endfunction

    regs_readback_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) && $past(reg_addr_in) inside {[pbv_pkg::SETUP_ADDR:pbv_pkg::FILTER_ADDR]}
        |-> reg_rdata_out == $past(rd_exp(reg_addr_in, setup_q, assign_q, filter_q, button_level_out)))
        else $error("register readback differs from written value");
    level_readback_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) && $past(reg_addr_in) == pbv_pkg::LEVEL_ADDR |-> reg_rdata_out == $past(button_level_out))
        else $error("level readback differs from level output");
    unmapped_read_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) && !($past(reg_addr_in) inside {[pbv_pkg::SETUP_ADDR:pbv_pkg::LEVEL_ADDR]})
        |-> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    select_gain_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) |-> conv_gain_out == $past(gain_exp(assign_q[2:0], button_level_out,
        {dac_channel_gain_reg_in, adc_channel_gain_reg_in})))
        else $error("converter gain select wrong");
    level_load_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) && $past(assign_q[2:0]) == 3'h7 && assign_q[2:0] != 3'h7
        |-> ##[0:1] button_level_out == (seen_q ? {1'b0, setup_q[7:3], 2'b00} : 8'hff))
        else $error("start level not loaded on activation");
    level_frozen_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) && assign_q[2:0] == 3'h7 && $past(assign_q[2:0]) == 3'h7 |-> $stable(button_level_out))
        else $error("level moved while buttons disabled");
    level_step_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) && assign_q[2:0] != 3'h7 && $past(assign_q[2:0]) != 3'h7 && $past(assign_q[2:0], 2) != 3'h7
        |-> {1'b0, button_level_out} <= {1'b0, $past(button_level_out)} + step_units(assign_q[7:6])
        && {1'b0, $past(button_level_out)} <= {1'b0, button_level_out} + step_units(assign_q[7:6]))
        else $error("level jumped by more than one step");
    step_needs_pin_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) && $past(assign_q[2:0]) != 3'h7 && $past(assign_q[2:0], 2) != 3'h7
        && $changed(button_level_out) |-> |pin_hist_q)
        else $error("level changed with no button pin high");
endmodule

bind pbv_ctrl pbv_ctrl_checker #(.NUM_PINS(NUM_PINS), .TICK_CYCLES(TICK_CYCLES)) i_checker (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rdata_out(reg_rdata_out),
    .multipurpose_pins_in(multipurpose_pins_in), .adc_channel_gain_reg_in(adc_channel_gain_reg_in),
    .dac_channel_gain_reg_in(dac_channel_gain_reg_in), .conv_gain_out(conv_gain_out),
    .button_level_out(button_level_out));

/* sim/push_button_volume_ctrl_test.sv */
// self-checking bench for the push-button volume control
`timescale 1ns/1ps
`define CHK(got, want) begin n_checks++; if ((got) !== (want)) begin failures++; $display("unexpected at %0t: got %h expected %h", $time, (got), (want)); end end
module push_button_volume_ctrl_test;
    logic        clk_sys_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [7:0]  reg_addr   = 8'h00;
    logic [7:0]  reg_wdata  = 8'h00;
    logic        reg_wr     = 1'b0;
    logic [7:0]  rdata;
    logic [4:0]  press      = 5'h00;
    logic        chatter    = 1'b0;
    logic [4:0]  pins;
    logic [31:0] adc_gain   = 32'h40302010;
    logic [15:0] dac_gain   = 16'h6050;
    logic [47:0] conv_gain;
    logic [7:0]  level;
    logic [5:0]  sel_tab[8] = '{6'h03, 6'h0c, 6'h0f, 6'h30, 6'h10, 6'h20, 6'h00, 6'h00};
    int          lvl        = 255;
    int          failures   = 0;
    int          n_checks   = 0;

    always #2.5 clk_sys_in = ~clk_sys_in;

    // two-cycle ticks shorten every time a hundredfold
    pbv_ctrl #(.NUM_PINS(5), .TICK_CYCLES(2)) i_dut (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_wr_in(reg_wr), .reg_rdata_out(rdata), .multipurpose_pins_in(pins),
        .pin_function_in({5'h0f, 5'h12, 5'h00, 5'h11, 5'h10}), .adc_channel_gain_reg_in(adc_gain),
        .dac_channel_gain_reg_in(dac_gain), .conv_gain_out(conv_gain), .button_level_out(level));

    pbv_buttons #(.NUM_PINS(5)) i_buttons (
        .clk_sys_in(clk_sys_in), .chatter_in(chatter), .press_in(press), .multipurpose_pins_out(pins));

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] want);
        @(posedge clk_sys_in);
        reg_addr <= a;
        repeat (2) @(posedge clk_sys_in);
        #1;
        `CHK(rdata, want)
    endtask

    // pin 0 lowers attenuation, pin 1 raises it; units of zero means the press must be ignored
    task automatic tap(input int g, input int len, input int units);
        @(posedge clk_sys_in);
        press[g] <= 1'b1;
        repeat (len) @(posedge clk_sys_in);
        press[g] <= 1'b0;
        repeat (60) @(posedge clk_sys_in);
        lvl = (g == 0) ? ((lvl > units) ? lvl - units : 0) : ((lvl + units < 255) ? lvl + units : 255);
        rd(pbv_pkg::LEVEL_ADDR, 8'(lvl));
        `CHK(level, 8'(lvl))
    endtask

    task automatic chk_gain(input logic [2:0] t);
        logic [47:0] want;
        repeat (3) @(posedge clk_sys_in);
        #1;
        want = {dac_gain, adc_gain};
        for (int i = 0; i < 6; i++) if (sel_tab[t][i]) want[i*8+:8] = 8'(lvl);
        `CHK(conv_gain, want)
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        rd(pbv_pkg::SETUP_ADDR, 8'h00);
        rd(pbv_pkg::ASSIGN_ADDR, 8'h87);
        rd(pbv_pkg::FILTER_ADDR, 8'h05);
        wr(8'h55, 8'hff);
        wr(pbv_pkg::LEVEL_ADDR, 8'h00);
        rd(8'h55, 8'h00);
        rd(pbv_pkg::LEVEL_ADDR, 8'hff);
        chk_gain(3'h7);
        done("reset");
        wr(pbv_pkg::FILTER_ADDR, 8'h07);
        adc_gain <= 32'h0f1e2d3c;
        rd(pbv_pkg::FILTER_ADDR, 8'h07);
        tap(0, 20, 0);
        chk_gain(3'h7);
        wr(pbv_pkg::ASSIGN_ADDR, 8'h80);
        rd(pbv_pkg::LEVEL_ADDR, 8'hff);
        wr(pbv_pkg::ASSIGN_ADDR, 8'h87);
        wr(pbv_pkg::SETUP_ADDR, 8'ha0);
        wr(pbv_pkg::ASSIGN_ADDR, 8'h80);
        lvl = 80;
        rd(pbv_pkg::LEVEL_ADDR, 8'h50);
        done("start level");
        for (int c = 0; c < 4; c++) begin
            wr(pbv_pkg::ASSIGN_ADDR, {c[1:0], 6'h00});
            tap(0, 20, (c == 0) ? 1 : c * 4);
            tap(1, 20, (c == 0) ? 1 : c * 4);
        end
        tap(2, 20, 0);
        done("gain steps");
        for (int t = 0; t < 7; t++) begin
            wr(pbv_pkg::ASSIGN_ADDR, {5'h10, t[2:0]});
            chk_gain(t[2:0]);
        end
        done("targets");
        wr(pbv_pkg::FILTER_ADDR, 8'h00);
        chatter <= 1'b1;
        tap(1, 400, 0);
        tap(1, 900, 8);
        done("debounce");
        @(posedge clk_sys_in) sys_rst_in <= 1'b1;
        repeat (20) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        lvl = 255;
        rd(pbv_pkg::ASSIGN_ADDR, 8'h87);
        rd(pbv_pkg::FILTER_ADDR, 8'h05);
        chk_gain(3'h7);
        done("second reset");
        print_verdict();
    end

    initial begin
        repeat (40000) @(posedge clk_sys_in);
        failures++;
        print_verdict();
    end
endmodule
